// File: rco_pin_mon.sv
// Watches the reference clock pin the way a consumer would: pulse and period lengths in bus clocks
module rco_pin_mon (
  // Clock
  input  wire logic clk_i,
  // Observed pin
  input  wire logic pin_i,
  // Measurements
  output int        hi_len_o,
  output int        per_len_o,
  output int        rises_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;
  int   hi_cnt;
  int   per_cnt;
  initial begin
    last = 1'h0;
    hi_cnt = 0;
    per_cnt = 0;
    hi_len_o = 0;
    per_len_o = 0;
    rises_o = 0;
  end
  always @(posedge clk_i) begin
    if (pin_i && !last) begin
      per_len_o <= per_cnt;
      per_cnt <= 1;
      hi_cnt <= 1;
      rises_o <= rises_o + 1;
    end else begin
      per_cnt <= per_cnt + 1;
      if (pin_i) hi_cnt <= hi_cnt + 1;
    end
    if (!pin_i && last) hi_len_o <= hi_cnt;
    last <= pin_i;
  end
endmodule

// File: rco_pkg.sv
package rco_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [13:0] IDX_CONTROL    = 14'h0f39;
  localparam logic [13:0] IDX_SOURCE_SEL = 14'h0f3a;
  localparam logic [13:0] IDX_STATUS     = 14'h0f3b;

  // Control and source select register layouts
  localparam int EN_BIT   = 7;
  localparam int DUTY_LSB = 3;
  localparam int DUTY_W   = 2;
  localparam int DIV_LSB  = 0;
  localparam int DIV_W    = 3;
  localparam int SRC_LSB  = 0;
  localparam int SRC_W    = 4;

  // Reset values
  localparam logic              EN_RST   = 1'b0;
  localparam logic [DUTY_W-1:0] DUTY_RST = 2'h2;
  localparam logic [DIV_W-1:0]  DIV_RST  = 3'h0;
  localparam logic [SRC_W-1:0]  SRC_RST  = 4'h0;

  // Source select codes
  localparam logic [SRC_W-1:0] SRC_SYSTEM   = 4'h0;
  localparam logic [SRC_W-1:0] SRC_HF_OSC   = 4'h1;
  localparam logic [SRC_W-1:0] SRC_SEC_OSC  = 4'h4;
  localparam logic [SRC_W-1:0] SRC_LC_FIRST = 4'h8;
  localparam logic [SRC_W-1:0] SRC_LC_BASE  = 4'h4;

  // External sources: four oscillators then eight logic cells
  localparam int NUM_EXT_SRC = 12;

  // Status register layout
  localparam int ST_RUN_BIT  = 0;
  localparam int ST_OUT_BIT  = 1;
  localparam int ST_RSVD_BIT = 2;
  localparam int ST_HALT_BIT = 3;

  // Half-period counter width (256 half periods at divide by 128)
  localparam int CNT_W = 8;

  // Returns {known, index into the synchronised source vector}
  function automatic logic [4:0] src_decode(input logic [SRC_W-1:0] code);
    logic [4:0] r;
    r = 5'h00;
    if (code >= SRC_LC_FIRST) begin
      r = {1'b1, code - SRC_LC_BASE};
    end else if (code >= SRC_HF_OSC && code <= SRC_SEC_OSC) begin
      r = {1'b1, code - SRC_HF_OSC};
    end
    return r;
  endfunction

endpackage

// File: rco_refclk.sv
// Operation
// - Four-bit source code picks system clock, oscillators, or logic cell outputs.
// - Setting enable starts the output cleanly, with no runt pulse.
// - Clearing enable stops the output immediately, mid-period if need be.
// - Divider field divides the source by two to the field value, up to 128.
// - With divider nonzero, duty gives 0, 25, 50 or 75 percent high time.
// - With divider zero, nonzero duty gives 50 percent; zero duty holds low.
// - Duty field resets to binary 10, giving 50 percent by default.
// - In sleep the output keeps running except when the system clock is selected.
// - Reference clock drives the output pin and an internal peripheral signal.
// - Control: enable bit 7, duty bits 4:3, divider bits 2:0; source bits 3:0.
//
// The Wishbone interface to the registers is this design's own decision.
module rco_refclk (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Clock sources
  input  wire logic        high_freq_internal_osc_i,
  input  wire logic        low_freq_internal_osc_i,
  input  wire logic        mid_freq_internal_osc_i,
  input  wire logic        secondary_osc_i,
  input  wire logic [7:0]  logic_cell_outputs_i,
  // Power state
  input  wire logic        sleep_i,
  // Reference clock
  output logic             reference_clock_out_o,
  output logic             reference_clock_oe_o,
  output logic             reference_clock_int_o
);

  // Register state
  logic                           en_q;
  logic [rco_pkg::DUTY_W-1:0]     duty_q;
  logic [rco_pkg::DIV_W-1:0]      div_q;
  logic [rco_pkg::SRC_W-1:0]      sel_q;

  // Bus state
  logic                           ack_q;
  logic [31:0]                    dat_q;

  // Waveform state
  logic                           run_q;
  logic                           run_d;
  logic [rco_pkg::CNT_W-1:0]      half_q;
  logic [rco_pkg::CNT_W-1:0]      half_d;
  logic                           out_q;
  logic                           out_d;
  logic                           oe_q;

  // Source path
  logic [rco_pkg::NUM_EXT_SRC-1:0] src_raw;
  logic [rco_pkg::NUM_EXT_SRC-1:0] src_sync;
  logic [4:0]                      src_dec;

  rco_src_if src ();

  // Bus decode
  logic [13:0] word_idx;
  logic        bus_req;
  logic        bus_wr;
  logic        hit_ctrl;
  logic        hit_src;
  logic        hit_stat;
  logic [7:0]  ctrl_rd;
  logic [7:0]  src_rd;
  logic [7:0]  stat_rd;
  logic [31:0] rd_mux;

  // Waveform decode
  logic [8:0]                period_halves;
  logic [rco_pkg::CNT_W-1:0] last_half;
  logic [9:0]                high_prod;
  logic [rco_pkg::CNT_W-1:0] high_halves;
  logic                      start;
  logic                      halted;
  logic                      src_rsvd;

  // ---------------------------------------------------------------------
  // Source synchronisation and selection
  // ---------------------------------------------------------------------
  assign src_raw = {logic_cell_outputs_i,
                    secondary_osc_i,
                    mid_freq_internal_osc_i,
                    low_freq_internal_osc_i,
                    high_freq_internal_osc_i};

  rco_sync #(
    .W (rco_pkg::NUM_EXT_SRC)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (src_raw),
    .sync_o  (src_sync)
  );

  // Sources must toggle slower than half the bus clock to be seen
  rco_src_sel u_src_sel (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .src_sync_i (src_sync),
    .sel_i      (sel_q),
    .sleep_i    (sleep_i),
    .src        (src)
  );

  assign src_dec  = rco_pkg::src_decode(sel_q);
  assign src_rsvd = ~src_dec[4] & (sel_q != rco_pkg::SRC_SYSTEM);
  assign halted   = en_q & sleep_i & (sel_q == rco_pkg::SRC_SYSTEM);

  // ---------------------------------------------------------------------
  // Wishbone slave: ack one cycle after the request, write on the edge that ends the ack cycle
  // ---------------------------------------------------------------------
  assign word_idx = adr_i[15:2];
  assign bus_req  = cyc_i & stb_i & ~ack_q;
  assign bus_wr   = cyc_i & stb_i & ack_q & we_i & sel_i[0];
  assign hit_ctrl = (word_idx == rco_pkg::IDX_CONTROL);
  assign hit_src  = (word_idx == rco_pkg::IDX_SOURCE_SEL);
  assign hit_stat = (word_idx == rco_pkg::IDX_STATUS);

  assign ctrl_rd = {en_q, 2'h0, duty_q, div_q};
  assign src_rd  = {4'h0, sel_q};
  assign stat_rd = {4'h0, halted, src_rsvd, out_q, run_q};

  // Unmapped words read as zero and ignore writes
  assign rd_mux = hit_ctrl ? {24'h000000, ctrl_rd} :
                  hit_src  ? {24'h000000, src_rd}  :
                  hit_stat ? {24'h000000, stat_rd} :
                             32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= bus_req;
      if (bus_req) begin
        dat_q <= rd_mux;
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // Field changes while enabled are taken as-is; glitch avoidance is up to software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q   <= rco_pkg::EN_RST;
      duty_q <= rco_pkg::DUTY_RST;
      div_q  <= rco_pkg::DIV_RST;
      sel_q  <= rco_pkg::SRC_RST;
    end else begin
      if (bus_wr && hit_ctrl) begin
        en_q   <= dat_i[rco_pkg::EN_BIT];
        duty_q <= dat_i[rco_pkg::DUTY_LSB +: rco_pkg::DUTY_W];
        div_q  <= dat_i[rco_pkg::DIV_LSB +: rco_pkg::DIV_W];
      end
      if (bus_wr && hit_src) begin
        sel_q <= dat_i[rco_pkg::SRC_LSB +: rco_pkg::SRC_W];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Divider and duty shaping, counted in source half periods
  // ---------------------------------------------------------------------
  assign period_halves = 9'h002 << div_q;
  assign last_half     = 8'(period_halves - 9'h001);
  assign high_prod     = {1'b0, period_halves} * {8'h00, duty_q};
  assign high_halves   = high_prod[9:2];

  // Start only on a source rising edge so the first high is full length
  assign start = en_q & ~run_q & src.rise;
  assign run_d = en_q & (run_q | src.rise);

  always_comb begin
    half_d = half_q;
    if (!en_q || start) begin
      half_d = '0;
    end else if (run_q && src.tick) begin
      half_d = (half_q == last_half) ? '0 : 8'(half_q + 8'h01);
    end
  end

  always_comb begin
    out_d = 1'b0;
    if (run_d) begin
      if (div_q == '0) begin
        out_d = (duty_q != '0) & src.level;
      end else begin
        out_d = (half_d < high_halves);
      end
    end
  end

  // Disable clears output and enable on the very next edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q  <= 1'b0;
      half_q <= '0;
      out_q  <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      run_q  <= run_d;
      half_q <= half_d;
      out_q  <= out_d;
      oe_q   <= en_q;
    end
  end

  // Pin and internal consumers see the same flop
  assign reference_clock_out_o = out_q;
  assign reference_clock_int_o = out_q;
  assign reference_clock_oe_o  = oe_q;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_src_route;
    src_dec[4] && $stable(sel_q) |->
      src.tick == (src_sync[src_dec[3:0]] != $past(src_sync[src_dec[3:0]]));
  endproperty
  a_src_route: assert property (p_src_route) else $error("tick not from selected source");

  property p_clean_start;
    $rose(out_q) && !$past(run_q) |-> $past(src.rise) && $past(en_q);
  endproperty
  a_clean_start: assert property (p_clean_start) else $error("output started off a source edge");

  property p_stop_now;
    !en_q |=> !reference_clock_out_o && !reference_clock_oe_o && !run_q;
  endproperty
  a_stop_now: assert property (p_stop_now) else $error("output still driven after disable");

  property p_div_wrap;
    en_q && run_q && src.tick && half_q == last_half && $stable(div_q) |=> half_q == '0;
  endproperty
  a_div_wrap: assert property (p_div_wrap) else $error("period length wrong");

  property p_duty_head;
    en_q && run_q && div_q != '0 && duty_q != '0 && half_q == '0 && $stable(duty_q)
      && $stable(div_q) |-> out_q;
  endproperty
  a_duty_head: assert property (p_duty_head) else $error("period did not start high");

  property p_duty_tail;
    en_q && run_q && div_q != '0 && half_q == last_half && $stable(duty_q)
      && $stable(div_q) |-> !out_q;
  endproperty
  a_duty_tail: assert property (p_duty_tail) else $error("period did not end low");

  property p_div0_zero;
    div_q == '0 && duty_q == '0 |=> !reference_clock_out_o;
  endproperty
  a_div0_zero: assert property (p_div0_zero) else $error("zero duty not held low");

  property p_div0_follow;
    en_q && run_q && div_q == '0 && duty_q != '0 |=> out_q == $past(src.level);
  endproperty
  a_div0_follow: assert property (p_div0_follow) else $error("undivided output not following source");

  property p_reset_vals;
    $fell(rst_i) |-> duty_q == rco_pkg::DUTY_RST && div_q == '0 && !en_q;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("control reset values wrong");

  property p_sleep_sys;
    sleep_i && $past(sleep_i) && sel_q == rco_pkg::SRC_SYSTEM && $stable(sel_q) |-> !src.tick;
  endproperty
  a_sleep_sys: assert property (p_sleep_sys) else $error("system clock source ran in sleep");

  property p_ctrl_write;
    bus_wr && hit_ctrl |=> en_q == $past(dat_i[7]) && duty_q == $past(dat_i[4:3])
      && div_q == $past(dat_i[2:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control fields not stored");

  property p_start_high;
    $rose(run_q) && duty_q != '0 |-> out_q;
  endproperty
  a_start_high: assert property (p_start_high) else $error("first period not high");

  property p_ack_answer;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");

  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

  property p_rd_ctrl;
    cyc_i && stb_i && !ack_o && hit_ctrl |=> dat_o[rco_pkg::EN_BIT] == $past(en_q)
      && dat_o[rco_pkg::DUTY_LSB +: rco_pkg::DUTY_W] == $past(duty_q) && dat_o[6:5] == 2'h0
      && dat_o[rco_pkg::DIV_LSB +: rco_pkg::DIV_W] == $past(div_q) && dat_o[31:8] == 24'h000000;
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read data wrong");

  property p_rd_unmapped;
    cyc_i && stb_i && !ack_o && !hit_ctrl && !hit_src && !hit_stat |=> dat_o == 32'h00000000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_src_write;
    bus_wr && hit_src |=> sel_q == $past(dat_i[rco_pkg::SRC_LSB +: rco_pkg::SRC_W]);
  endproperty
  a_src_write: assert property (p_src_write) else $error("source select not stored");

  property p_no_sel_write;
    cyc_i && stb_i && ack_o && !sel_i[0]
      |=> $stable(en_q) && $stable(duty_q) && $stable(div_q) && $stable(sel_q);
  endproperty
  a_no_sel_write: assert property (p_no_sel_write) else $error("write without byte enable landed");

  property p_sleep_ext;
    sleep_i && en_q && run_q && src_dec[4] && src.tick && half_q != last_half
      |=> half_q == 8'($past(half_q) + 8'h01);
  endproperty
  a_sleep_ext: assert property (p_sleep_ext) else $error("external source stalled in sleep");

  property p_stat_halt;
    cyc_i && stb_i && !ack_o && hit_stat
      |=> dat_o[rco_pkg::ST_HALT_BIT] == $past(en_q && sleep_i && sel_q == rco_pkg::SRC_SYSTEM);
  endproperty
  a_stat_halt: assert property (p_stat_halt) else $error("halted status wrong");

  property p_oe_follow;
    en_q |=> reference_clock_oe_o;
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("pin not driven while enabled");

  property p_half_step;
    en_q && run_q && !src.tick |=> $stable(half_q);
  endproperty
  a_half_step: assert property (p_half_step) else $error("divider moved without a source edge");

  property p_rsvd_quiet;
    src_rsvd && $stable(sel_q) |-> !src.tick && !src.level;
  endproperty
  a_rsvd_quiet: assert property (p_rsvd_quiet) else $error("reserved source produced edges");

  property p_stop_half;
    !en_q |=> half_q == '0 && !reference_clock_int_o;
  endproperty
  a_stop_half: assert property (p_stop_half) else $error("divider not cleared on disable");

endmodule

// File: rco_src_if.sv
interface rco_src_if;
  logic tick;
  logic rise;
  logic level;

  modport drv (
    output tick,
    output rise,
    output level
  );

  modport snk (
    input  tick,
    input  rise,
    input  level
  );
endinterface

// File: rco_src_sel.sv
module rco_src_sel (
  // Clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  // Configuration
  input  wire logic [rco_pkg::NUM_EXT_SRC-1:0]     src_sync_i,
  input  wire logic [rco_pkg::SRC_W-1:0]           sel_i,
  input  wire logic                                sleep_i,
  // Selected source events
  rco_src_if.drv                                   src
);

  logic [4:0] dec;
  logic       ext_level;
  logic       level;
  logic       phase_q;
  logic       prev_q;

  assign dec       = rco_pkg::src_decode(sel_i);
  assign ext_level = dec[4] & src_sync_i[dec[3:0]];
  // The system clock cannot be sampled as data, so it is modelled as a
  // phase flop toggling every cycle; it freezes in sleep
  assign level     = (sel_i == rco_pkg::SRC_SYSTEM) ? phase_q : ext_level;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      phase_q <= sleep_i ? phase_q : ~phase_q;
      prev_q  <= level;
    end
  end

  assign src.level = level;
  assign src.tick  = level ^ prev_q;
  assign src.rise  = level & ~prev_q;

endmodule

// File: rco_sync.sv
module rco_sync #(
  parameter int W = 12
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        meta_q[g] <= 1'b0;
        sync_o[g] <= 1'b0;
      end else begin
        meta_q[g] <= async_i[g];
        sync_o[g] <= meta_q[g];
      end
    end
  end

endmodule

// File: reference_clock_output_tb.sv
module reference_clock_output_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CTL = {rco_pkg::IDX_CONTROL, 2'h0};
  localparam logic [15:0] SRC = {rco_pkg::IDX_SOURCE_SEL, 2'h0};
  localparam logic [15:0] STS = {rco_pkg::IDX_STATUS, 2'h0};
  localparam logic [15:0] UNM = 16'h3d00;
  logic        clk_i, rst_i, cyc, stb, we, sleep;
  logic [15:0] adr;
  logic [3:0]  sel;
  logic [31:0] dat, q;
  logic [7:0]  lc_m, tcnt;
  wire  [31:0] dat_o;
  wire         ack, out, oe, ck_int;
  int          errors, n_compared, hi_len, per_len, rises, seed;

  rco_refclk DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack),
    .high_freq_internal_osc_i(tcnt[1]), .low_freq_internal_osc_i(tcnt[2]),
    .mid_freq_internal_osc_i(tcnt[3]), .secondary_osc_i(tcnt[4]),
    .logic_cell_outputs_i(lc_m & {8{tcnt[2]}}), .sleep_i(sleep),
    .reference_clock_out_o(out), .reference_clock_oe_o(oe), .reference_clock_int_o(ck_int)
  );
  rco_pin_mon mon (.clk_i(clk_i), .pin_i(out), .hi_len_o(hi_len), .per_len_o(per_len), .rises_o(rises));

  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Oscillators run at distinct rates and only the selected logic cell toggles, so a wrong selection shows up as a wrong period or no edges
  always @(posedge clk_i) tcnt <= tcnt + 8'h1;

  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tmo(input string nm);
    errors++;
    $display("BAD %s timed out", nm);
    report_and_stop();
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d, input logic s);
    int i;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    sel <= {3'h0, s};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'h1 && i < 50);
    q = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (i >= 50) tmo("ack");
  endtask

  function automatic int bp(input logic [3:0] c);
    if (c >= 4'h8) return 8;
    return 2 << c;
  endfunction

  function automatic int ehi(input logic [3:0] c, input logic [2:0] d, input logic [1:0] u);
    if (c inside {4'h5, 4'h6, 4'h7} || u == 2'h0) return 0;
    if (d == 3'h0) return bp(c) / 2;
    return (bp(c) << d) * u / 4;
  endfunction

  // Configure while disabled, enable, then measure the very first pulse and period
  task automatic run(input logic [3:0] c, input logic [2:0] d, input logic [1:0] u);
    int r0, k, p;
    p = bp(c) << d;
    lc_m <= (c >= 4'h8) ? 8'h01 << (c - 4'h8) : 8'h00;
    wb(1'h1, SRC, {4'h0, c}, 1'h1);
    wb(1'h1, CTL, {3'h0, u, d}, 1'h1);
    wb(1'h1, CTL, {3'h4, u, d}, 1'h1);
    r0 = rises;
    if (ehi(c, d, u) == 0) begin
      repeat (300) @(posedge clk_i);
      chk("no_edges", r0, rises);
      wb(1'h0, STS, 8'h0, 1'h0);
      chk("rsvd", (c inside {4'h5, 4'h6, 4'h7}) ? 32'h1 : 32'h0, q[rco_pkg::ST_RSVD_BIT]);
    end else begin
      for (k = 0; k < 4 * p + 100 && rises < r0 + 2; k++) @(posedge clk_i);
      #1;
      if (rises < r0 + 2) tmo("rises");
      chk("first_high", ehi(c, d, u), hi_len);
      chk("first_period", p, per_len);
      chk("oe", 32'h1, oe);
      wb(1'h0, STS, 8'h0, 1'h0);
      chk("running", 32'h1, q[rco_pkg::ST_RUN_BIT]);
    end
    wb(1'h1, CTL, {3'h0, u, d}, 1'h1);
  endtask

  always @(negedge clk_i) if (rst_i === 1'h0) chk("int_pin", out, ck_int);

  initial begin
    int r0, k, r;
    seed = 32'h501c2929;
    rst_i = 1'h1;
    {cyc, stb, we, sleep} = 4'h0;
    adr = 16'h0;
    sel = 4'h0;
    dat = 32'h0;
    lc_m = 8'h0;
    tcnt = 8'h0;
    errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, CTL, 8'h0, 1'h0);
    chk("ctl_rst", 32'h10, q);
    wb(1'h0, SRC, 8'h0, 1'h0);
    chk("src_rst", 32'h0, q);
    wb(1'h1, CTL, 8'h7f, 1'h0);
    wb(1'h0, CTL, 8'h0, 1'h0);
    chk("ctl_nosel", 32'h10, q);
    wb(1'h1, CTL, 8'h6f, 1'h1);
    wb(1'h0, CTL, 8'h0, 1'h0);
    chk("ctl_rw", 32'h0f, q);
    wb(1'h1, SRC, 8'hf3, 1'h1);
    wb(1'h0, SRC, 8'h0, 1'h0);
    chk("src_rw", 32'h03, q);
    wb(1'h1, UNM, 8'hff, 1'h1);
    wb(1'h0, UNM, 8'h0, 1'h0);
    chk("unmapped", 32'h0, q);
    for (int c = 0; c < 16; c++) run(c[3:0], 3'h1, 2'h2);
    for (int u = 0; u < 4; u++) run(4'h1, 3'h0, u[1:0]);
    for (int u = 0; u < 4; u++) run(4'h2, 3'h3, u[1:0]);
    run(4'h1, 3'h7, 2'h3);
    run(4'h4, 3'h7, 2'h1);
    repeat (12) begin
      r = $random(seed);
      run(r[3:0], r[6:4] % 3'h5, r[9:8]);
    end
    // Clear enable in the middle of a long high phase
    wb(1'h1, SRC, 8'h04, 1'h1);
    wb(1'h1, CTL, 8'h9c, 1'h1);
    for (k = 0; k < 3000 && out !== 1'h1; k++) @(posedge clk_i);
    if (out !== 1'h1) tmo("high");
    repeat (20) @(posedge clk_i);
    wb(1'h1, CTL, 8'h1c, 1'h1);
    @(posedge clk_i);
    #1;
    chk("stop_out", 32'h0, out);
    chk("stop_oe", 32'h0, oe);
    // Sleep freezes only the system clock source
    wb(1'h1, SRC, 8'h00, 1'h1);
    wb(1'h1, CTL, 8'h91, 1'h1);
    repeat (20) @(posedge clk_i);
    sleep <= 1'h1;
    repeat (5) @(posedge clk_i);
    r0 = rises;
    repeat (100) @(posedge clk_i);
    chk("sleep_sys", r0, rises);
    wb(1'h0, STS, 8'h0, 1'h0);
    chk("halted", 32'h1, q[rco_pkg::ST_HALT_BIT]);
    wb(1'h1, CTL, 8'h11, 1'h1);
    wb(1'h1, SRC, 8'h01, 1'h1);
    wb(1'h1, CTL, 8'h91, 1'h1);
    r0 = rises;
    repeat (100) @(posedge clk_i);
    chk("sleep_osc", 32'h1, rises > r0 + 10);
    sleep <= 1'h0;
    report_and_stop();
  end
endmodule
